// [rtl/nvm_record_validator_consts.svh]
/*
  Named constants for the record validator: command codes, status codes,
  record type codes, header layout and start address.
  Assumes the includer is a package or module compiled after this file.
*/
`ifndef NVM_RECORD_VALIDATOR_CONSTS_SVH
`define NVM_RECORD_VALIDATOR_CONSTS_SVH

// ****************************************
// Command codes
// ****************************************
`define CMD_VALIDATE   16'h850D
`define CMD_VAL_STATUS 16'h850E
`define CMD_CONFIG     16'h850A
`define CMD_ERASE_BLK  16'h8506
`define CMD_ERASE_DEV  16'h8507
`define CMD_WRITE      16'h8505

// ****************************************
// Status codes
// ****************************************
`define ST_ENOERR   8'h00
`define ST_ENODEV   8'h13
`define ST_ENOMEM   8'h0C
`define ST_EBUSY    8'h10
`define ST_EACCES   8'h0D
`define ST_ENOSYS   8'h26
`define ST_EBADSUM  8'h4A
`define ST_ENOTCFG  8'h01

// ****************************************
// Record layout
// ****************************************
`define REC_NULL      8'h00
`define REC_EXT_NULL  8'hFF
`define REC_DIR       8'h01
`define REC_META_LAST 8'h0F
`define HDR_TYPE      3'h0
`define HDR_LEN_HI    3'h1
`define HDR_LEN_LO    3'h2
`define HDR_SUM_HI    3'h3
`define HDR_SUM_LO    3'h4
`define NVM_BASE      32'h0000_0000

`endif

// [rtl/nvm_record_validator_pkg.sv]
/*
  Types for the record validator: walker states and the packed state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nvm_record_validator_pkg;

  // Walker states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_HDR  = 2'b01,
    S_BODY = 2'b10
  } walk_e;

  // All state of the validator
  typedef struct packed {
    walk_e       st;
    logic        meta_only;
    logic        demand;
    logic        lock;
    logic        ram;
    logic        cfg_done;
    logic        rd_req;
    logic [31:0] addr;
    logic [31:0] rec_addr;
    logic [2:0]  hdr_idx;
    logic [15:0] remain;
    logic [7:0]  rtype;
    logic [15:0] rlen;
    logic [15:0] rsum;
    logic [15:0] csum;
    logic [15:0] count;
    logic [7:0]  last_err;
    logic [7:0]  f_type;
    logic [15:0] f_len;
    logic [15:0] f_sum;
    logic [15:0] f_calc;
    logic [31:0] f_addr;
    logic        rsp_valid;
    logic [7:0]  rsp_status;
    logic        fwd_valid;
    logic [15:0] fwd_code;
    logic        dmd_done;
    logic        dmd_ok;
  } state_s;

endpackage

// [rtl/nvm_record_validator.sv]
/*
  Record validation command handler: walks stored records, checks checksums,
  owns the flash lock and the borrowed patch RAM, answers status queries.
  Assumes a byte-wide memory read port answering in the cycle of rd_valid.
*/
`include "nvm_record_validator_consts.svh"

module nvm_record_validator
  import nvm_record_validator_pkg::*;
#(
  parameter logic [15:0] RECORD_BUF_BYTES = 16'h0100
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_code,
  input  wire logic [7:0]  cmd_param,
  input  wire logic        cmd_from_init,
  input  wire logic        host_owns_lock,
  input  wire logic        lock_taken_elsewhere,
  input  wire logic        flash_busy,
  input  wire logic        nvm_present,
  input  wire logic        virtual_image,
  input  wire logic [15:0] ram_free_bytes,
  input  wire logic        demand_valid,
  input  wire logic [31:0] demand_addr,
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_data,
  output logic             rsp_valid,
  output logic [7:0]       rsp_status,
  output logic             fwd_valid,
  output logic [15:0]      fwd_code,
  output logic             rd_req,
  output logic [31:0]      rd_addr,
  output logic             lock_held,
  output logic             ram_borrowed,
  output logic             config_done,
  output logic             busy,
  output logic             demand_done,
  output logic             demand_ok,
  output logic [7:0]       res_error,
  output logic [7:0]       res_type,
  output logic [15:0]      res_length,
  output logic [15:0]      res_stored_sum,
  output logic [15:0]      res_computed_sum,
  output logic [31:0]      res_fail_addr,
  output logic [15:0]      res_count
);

  // ****************************************
  // Helpers
  // ****************************************

  // Metadata type codes sit in one range, all others are data
  function automatic logic is_meta(input logic [7:0] t);
    return (t >= `REC_DIR) && (t <= `REC_META_LAST);
  endfunction

  // End of a walk: return lock and RAM, record outcome
  function automatic state_s finish(input state_s s, input logic [7:0] code);
    state_s r;
    r = s;
    r.st = S_IDLE;
    r.rd_req = 1'b0;
    r.lock = 1'b0;
    r.ram = 1'b0;
    r.dmd_done = s.demand;
    r.dmd_ok = (code == `ST_ENOERR);
    if (!s.demand) begin
      r.last_err = code;
    end
    if (code != `ST_ENOERR) begin
      r.f_type = s.rtype;
      r.f_len = s.rlen;
      r.f_sum = s.rsum;
      r.f_calc = s.csum;
      r.f_addr = s.rec_addr;
    end
    return r;
  endfunction

  state_s st_ff;
  state_s nxt_st;

  // ****************************************
  // Next state
  // ****************************************

  // Command decode and record walker
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.fwd_valid = 1'b0;
    nxt_st.dmd_done = 1'b0;
    if (cmd_valid) begin
      nxt_st.rsp_valid = 1'b1;
      nxt_st.rsp_status = `ST_ENOSYS;
      case (cmd_code)
        `CMD_VALIDATE: begin
          if (st_ff.st != S_IDLE || flash_busy) begin
            nxt_st.rsp_status = `ST_EBUSY;
          end else if (!nvm_present) begin
            nxt_st.rsp_status = `ST_ENODEV;
          end else if (virtual_image) begin
            nxt_st.rsp_status = `ST_ENOSYS;
          end else if (lock_taken_elsewhere) begin
            nxt_st.rsp_status = `ST_EACCES;
          end else if (ram_free_bytes < RECORD_BUF_BYTES) begin
            nxt_st.rsp_status = `ST_ENOMEM;
          end else begin
            nxt_st.rsp_status = `ST_ENOERR;
            nxt_st.st = S_HDR;
            nxt_st.meta_only = (cmd_param != 8'h00);
            nxt_st.demand = 1'b0;
            nxt_st.lock = 1'b1;
            nxt_st.ram = 1'b1;
            nxt_st.addr = `NVM_BASE;
            nxt_st.rec_addr = `NVM_BASE;
            nxt_st.hdr_idx = `HDR_TYPE;
            nxt_st.count = 16'h0000;
            nxt_st.last_err = `ST_ENOERR;
          end
        end
        `CMD_VAL_STATUS: begin
          nxt_st.rsp_status = (st_ff.st != S_IDLE && !st_ff.demand) ? `ST_EBUSY : `ST_ENOERR;
        end
        `CMD_CONFIG: begin
          if (cmd_from_init || host_owns_lock) begin
            nxt_st.cfg_done = 1'b1;
            nxt_st.rsp_status = `ST_ENOERR;
          end else begin
            nxt_st.rsp_status = `ST_EACCES;
          end
        end
        `CMD_ERASE_BLK, `CMD_ERASE_DEV, `CMD_WRITE: begin
          if (!st_ff.cfg_done) begin
            nxt_st.rsp_status = `ST_ENOTCFG;
          end else begin
            nxt_st.rsp_status = `ST_ENOERR;
            nxt_st.fwd_valid = 1'b1;
            nxt_st.fwd_code = cmd_code;
          end
        end
        default: begin
          nxt_st.rsp_status = `ST_ENOSYS;
        end
      endcase
    end else if (demand_valid && st_ff.st == S_IDLE && !lock_taken_elsewhere &&
                 ram_free_bytes >= RECORD_BUF_BYTES) begin
      nxt_st.st = S_HDR;
      nxt_st.demand = 1'b1;
      nxt_st.lock = 1'b1;
      nxt_st.ram = 1'b1;
      nxt_st.addr = demand_addr;
      nxt_st.rec_addr = demand_addr;
      nxt_st.hdr_idx = `HDR_TYPE;
    end
    case (st_ff.st)
      S_HDR: begin
        if (rd_valid) begin
          nxt_st.addr = st_ff.addr + 32'h0000_0001;
          nxt_st.hdr_idx = st_ff.hdr_idx + 3'h1;
          case (st_ff.hdr_idx)
            `HDR_TYPE: begin
              nxt_st.rtype = rd_data;
              if (!st_ff.demand && st_ff.rec_addr == `NVM_BASE && rd_data != `REC_DIR) begin
                nxt_st = finish(nxt_st, `ST_ENODEV);
              end else if (rd_data == `REC_NULL || rd_data == `REC_EXT_NULL) begin
                nxt_st = finish(nxt_st, `ST_ENOERR);
              end
            end
            `HDR_LEN_HI: nxt_st.rlen = {rd_data, st_ff.rlen[7:0]};
            `HDR_LEN_LO: nxt_st.rlen = {st_ff.rlen[15:8], rd_data};
            `HDR_SUM_HI: nxt_st.rsum = {rd_data, st_ff.rsum[7:0]};
            default: begin
              nxt_st.rsum = {st_ff.rsum[15:8], rd_data};
              if (st_ff.meta_only && !st_ff.demand && !is_meta(st_ff.rtype)) begin
                nxt_st.addr = st_ff.addr + 32'h0000_0001 + {16'h0000, st_ff.rlen};
                nxt_st.rec_addr = nxt_st.addr;
                nxt_st.hdr_idx = `HDR_TYPE;
              end else begin
                nxt_st.st = S_BODY;
                nxt_st.remain = st_ff.rlen;
                nxt_st.csum = 16'h0000;
              end
            end
          endcase
        end
      end
      S_BODY: begin
        if (st_ff.remain == 16'h0000) begin
          nxt_st.count = st_ff.count + 16'h0001;
          if (st_ff.csum != st_ff.rsum) begin
            nxt_st = finish(nxt_st, `ST_EBADSUM);
          end else if (st_ff.demand) begin
            nxt_st = finish(nxt_st, `ST_ENOERR);
          end else begin
            nxt_st.st = S_HDR;
            nxt_st.rec_addr = st_ff.addr;
            nxt_st.hdr_idx = `HDR_TYPE;
          end
        end else if (rd_valid) begin
          nxt_st.csum = st_ff.csum + {8'h00, rd_data};
          nxt_st.remain = st_ff.remain - 16'h0001;
          nxt_st.addr = st_ff.addr + 32'h0000_0001;
        end
      end
      default: begin
      end
    endcase
    nxt_st.rd_req = (nxt_st.st == S_HDR) || (nxt_st.st == S_BODY && nxt_st.remain != 16'h0000);
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // All outputs come from the state register
  assign rsp_valid = st_ff.rsp_valid;
  assign rsp_status = st_ff.rsp_status;
  assign fwd_valid = st_ff.fwd_valid;
  assign fwd_code = st_ff.fwd_code;
  assign rd_req = st_ff.rd_req;
  assign rd_addr = st_ff.addr;
  assign lock_held = st_ff.lock;
  assign ram_borrowed = st_ff.ram;
  assign config_done = st_ff.cfg_done;
  assign busy = st_ff.lock; // Lock flop is set exactly while a walk runs
  assign demand_done = st_ff.dmd_done;
  assign demand_ok = st_ff.dmd_ok;
  assign res_error = st_ff.last_err;
  assign res_type = st_ff.f_type;
  assign res_length = st_ff.f_len;
  assign res_stored_sum = st_ff.f_sum;
  assign res_computed_sum = st_ff.f_calc;
  assign res_fail_addr = st_ff.f_addr;
  assign res_count = st_ff.count;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  lock_while_walk_a: assert property ((st_ff.st == S_IDLE) == !st_ff.lock)
    else $error("lock not tied to walk");
  ram_with_lock_a: assert property (st_ff.ram == st_ff.lock)
    else $error("buffer not tied to lock");
  busy_answer_a: assert property (cmd_valid && cmd_code == `CMD_VALIDATE && busy
      |=> rsp_valid && rsp_status == `ST_EBUSY)
    else $error("busy validate not refused");
  start_walk_a: assert property (cmd_valid && cmd_code == `CMD_VALIDATE && !busy && !flash_busy
      && nvm_present && !virtual_image && !lock_taken_elsewhere
      && ram_free_bytes >= RECORD_BUF_BYTES |=> rsp_status == `ST_ENOERR && lock_held && rd_req
      && rd_addr == `NVM_BASE)
    else $error("validate not started");
  erase_refused_a: assert property (cmd_valid && cmd_code == `CMD_ERASE_BLK && !config_done
      |=> rsp_status == `ST_ENOTCFG && !fwd_valid)
    else $error("erase passed unconfigured");
  init_config_a: assert property (cmd_valid && cmd_code == `CMD_CONFIG && cmd_from_init
      |=> config_done && rsp_status == `ST_ENOERR)
    else $error("init config not taken");
  bad_sum_a: assert property (st_ff.st == S_BODY && st_ff.remain == 16'h0000
      && st_ff.csum != st_ff.rsum && !st_ff.demand |=> !busy && res_error == `ST_EBADSUM
      && res_count == $past(res_count) + 16'h0001 && res_computed_sum == $past(st_ff.csum))
    else $error("mismatch not reported");
  no_dev_a: assert property (cmd_valid && cmd_code == `CMD_VALIDATE && !busy && !flash_busy
      && !nvm_present |=> rsp_status == `ST_ENODEV ##1 !lock_held)
    else $error("absent memory not reported");
  null_end_a: assert property (st_ff.st == S_HDR && st_ff.hdr_idx == `HDR_TYPE && rd_valid
      && rd_data == `REC_NULL |=> !busy && !lock_held)
    else $error("null record did not end walk");
  query_busy_a: assert property (cmd_valid && cmd_code == `CMD_VAL_STATUS && busy
      && !st_ff.demand |=> rsp_status == `ST_EBUSY)
    else $error("query missed busy");

endmodule

// [testbench/nvm_byte_model.sv]
/*
  Byte-wide memory model that answers the validator's record reads.
  Assumes the bench writes mem directly while no walk is running.
*/
module nvm_byte_model (
  input wire logic clk,
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:4095];
  logic [1:0] wait_cnt;
  initial begin
    rd_valid = 1'b0;
    rd_data = 8'h00;
    wait_cnt = 2'h0;
  end
  // Answers are 1 to 4 idle cycles apart under steady requests; the data line toggles when not valid
  always @(posedge clk) begin
    if (rd_valid) begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      wait_cnt <= 2'($urandom_range(0, 3));
    end else if (rd_req && wait_cnt == 2'h0) begin
      rd_valid <= 1'b1;
      rd_data <= mem[rd_addr[11:0]];
    end else begin
      rd_data <= ~rd_data;
      if (rd_req) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule

// [testbench/nvm_record_validator_tb_top.sv]
/*
  Self-checking bench for the record validator: commands, walks, refusals.
  Assumes nvm_byte_model as the memory and the design constants header.
*/
`include "nvm_record_validator_consts.svh"
module nvm_record_validator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] BUF_B = 16'h0100;
  logic clk, sys_rst, cmd_valid, cmd_from_init, host_owns_lock, lock_taken_elsewhere;
  logic flash_busy, nvm_present, virtual_image, demand_valid, rd_valid, fbad;
  logic rsp_valid, fwd_valid, rd_req, lock_held, ram_borrowed, config_done, busy;
  logic demand_done, demand_ok;
  logic [7:0] cmd_param, rd_data, rsp_status, res_error, res_type, f_t;
  logic [15:0] cmd_code, ram_free_bytes, fwd_code, res_length, res_stored_sum;
  logic [15:0] res_computed_sum, res_count, f_l, f_s, f_c;
  logic [31:0] demand_addr, rd_addr, res_fail_addr, f_a, bad_at, good_at;
  logic [7:0] ref_st [0:4];
  int err_count, cmp_count, wp, e_all, e_meta, n;

  // ****************************************
  // Design and memory
  // ****************************************
  nvm_record_validator #(.RECORD_BUF_BYTES(BUF_B)) i_dut (.clk, .sys_rst, .cmd_valid,
    .cmd_code, .cmd_param, .cmd_from_init, .host_owns_lock, .lock_taken_elsewhere,
    .flash_busy, .nvm_present, .virtual_image, .ram_free_bytes, .demand_valid,
    .demand_addr, .rd_valid, .rd_data, .rsp_valid, .rsp_status, .fwd_valid, .fwd_code,
    .rd_req, .rd_addr, .lock_held, .ram_borrowed, .config_done, .busy, .demand_done,
    .demand_ok, .res_error, .res_type, .res_length, .res_stored_sum, .res_computed_sum,
    .res_fail_addr, .res_count);
  nvm_byte_model i_mem (.clk, .rd_req, .rd_addr, .rd_valid, .rd_data);

  // Clock source
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait for end of walk or for a finished demand check
  task automatic wait_sig(input bit dmd);
    for (n = 0; n < 20000; n++) begin
      @(posedge clk);
      #1;
      if (dmd ? demand_done === 1'b1 : busy === 1'b0) return;
    end
    err_count++;
    $display("Error wait expected done seen timeout");
    report_and_stop();
  endtask

  // One command pulse; answer is looked at in its single cycle
  task automatic cmd(input logic [15:0] code, input logic [7:0] prm, input logic [7:0] exp);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_param <= prm;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("rsp_valid", 32'h1, 32'(rsp_valid));
    chk("rsp_status", 32'(exp), 32'(rsp_status));
  endtask

  // Write one record and update the expected counts and failure fields
  task automatic add_rec(input logic [7:0] t, input int len, input bit bad);
    logic [15:0] s;
    logic [7:0] b;
    s = 16'h0000;
    if (!fbad) e_all++;
    if (t <= 8'h0F) e_meta++;
    if (bad) bad_at = 32'(wp);
    else if (t > 8'h0F) good_at = 32'(wp);
    i_mem.mem[wp] = t;
    {i_mem.mem[wp+1], i_mem.mem[wp+2]} = 16'(len);
    for (int k = 0; k < len; k++) begin
      b = 8'($urandom);
      i_mem.mem[wp+5+k] = b;
      s = s + 16'(b);
    end
    {i_mem.mem[wp+3], i_mem.mem[wp+4]} = bad ? s + 16'h0001 : s;
    if (bad && !fbad) begin
      fbad = 1'b1;
      {f_t, f_l, f_s, f_c, f_a} = {t, 16'(len), s + 16'h0001, s, 32'(wp)};
    end
    wp += 5 + len;
  endtask

  // Mixed image; bad one carries a corrupt data record and a null end
  task automatic img(input bit bad);
    {wp, e_all, e_meta, fbad} = '0;
    add_rec(8'h01, $urandom_range(1, 8), 1'b0);
    add_rec(8'h10, $urandom_range(1, 6), bad);
    add_rec(8'h0F, bad ? 2 : 0, 1'b0);
    add_rec(8'h22, $urandom_range(1, 6), 1'b0);
    i_mem.mem[wp] = bad ? 8'h00 : 8'hFF;
  endtask

  task automatic run(input logic [7:0] prm, input logic [7:0] err, input int cnt);
    cmd(`CMD_VALIDATE, prm, `ST_ENOERR);
    chk("lock_held", 32'h1, 32'(lock_held));
    chk("ram_borrowed", 32'h1, 32'(ram_borrowed));
    cmd(`CMD_VALIDATE, prm, `ST_EBUSY);
    // A missing directory ends the walk within a few cycles, so no busy query then
    if (cnt >= 0) cmd(`CMD_VAL_STATUS, 8'h00, `ST_EBUSY);
    wait_sig(1'b0);
    chk("lock_held", 32'h0, 32'(lock_held));
    chk("ram_borrowed", 32'h0, 32'(ram_borrowed));
    chk("res_error", 32'(err), 32'(res_error));
    if (cnt >= 0) chk("res_count", 32'(cnt), 32'(res_count));
    cmd(`CMD_VAL_STATUS, 8'h00, `ST_ENOERR);
  endtask

  task automatic demand(input logic [31:0] a, input logic ok);
    @(posedge clk);
    demand_valid <= 1'b1;
    demand_addr <= a;
    @(posedge clk);
    demand_valid <= 1'b0;
    wait_sig(1'b1);
    chk("demand_ok", 32'(ok), 32'(demand_ok));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h5b0d1da7));
    {err_count, cmp_count} = '0;
    {cmd_valid, cmd_from_init, lock_taken_elsewhere, flash_busy, virtual_image} = '0;
    host_owns_lock = 1'b0;
    {demand_valid, cmd_code, cmd_param, demand_addr} = '0;
    {sys_rst, nvm_present, ram_free_bytes} = {1'b1, 1'b1, BUF_B};
    ref_st = '{`ST_EBUSY, `ST_ENODEV, `ST_ENOSYS, `ST_EACCES, `ST_ENOMEM};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("idle outputs", 32'h0, 32'({rsp_valid, lock_held, busy, config_done, res_count}));
    cmd(`CMD_ERASE_BLK, 8'h00, `ST_ENOTCFG);
    cmd(`CMD_WRITE, 8'h00, `ST_ENOTCFG);
    cmd(`CMD_CONFIG, 8'h00, `ST_EACCES);
    @(posedge clk);
    cmd_from_init <= 1'b1;
    cmd(`CMD_CONFIG, 8'h00, `ST_ENOERR);
    // Configuration by a host that owns the lock, dropped again before validation
    @(posedge clk);
    {cmd_from_init, host_owns_lock} <= 2'b01;
    cmd(`CMD_CONFIG, 8'h00, `ST_ENOERR);
    @(posedge clk);
    host_owns_lock <= 1'b0;
    chk("config_done", 32'h1, 32'(config_done));
    cmd(`CMD_ERASE_DEV, 8'h00, `ST_ENOERR);
    chk("fwd_code", 32'({fwd_valid, `CMD_ERASE_DEV}), 32'({fwd_valid, fwd_code}));
    cmd(16'h1234, 8'h00, `ST_ENOSYS);
    // Each refusal condition alone, RAM one byte short for the last
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {flash_busy, virtual_image, lock_taken_elsewhere} <= {i == 0, i == 2, i == 3};
      nvm_present <= (i != 1);
      ram_free_bytes <= (i == 4) ? BUF_B - 16'h0001 : BUF_B;
      cmd(`CMD_VALIDATE, 8'h00, ref_st[i]);
    end
    @(posedge clk);
    ram_free_bytes <= BUF_B;
    img(1'b0);
    run(8'h00, `ST_ENOERR, e_all);
    run(8'($urandom_range(1, 255)), `ST_ENOERR, e_meta);
    img(1'b1);
    run(8'h00, `ST_EBADSUM, e_all);
    chk("res_type", 32'(f_t), 32'(res_type));
    chk("res_length", 32'(f_l), 32'(res_length));
    chk("res_stored_sum", 32'(f_s), 32'(res_stored_sum));
    chk("res_computed_sum", 32'(f_c), 32'(res_computed_sum));
    chk("res_fail_addr", f_a, res_fail_addr);
    run(8'h01, `ST_ENOERR, e_meta);
    demand(bad_at, 1'b0);
    demand(good_at, 1'b1);
    {wp, e_all, e_meta, fbad} = '0;
    add_rec(8'h20, 3, 1'b0);
    i_mem.mem[wp] = 8'h00;
    run(8'h00, `ST_ENODEV, -1);
    report_and_stop();
  end
endmodule
